// >>> rtl/shp_pin_if.sv
// Pin-level host interface: power pins, serial ports and parallel pixel bus.
//
// Contract
// - The slave serial port answers at 0x78 with address select low and 0x7A with it high.
// - A high standby pin puts the device in standby and a low level means normal running.
// - A low master reset pin resets the device, and a floating pin must not hold it in reset.
// - The shutdown pin puts the device in full shutdown with its internal supplies off.
// - Standby turns off the core rail unless it is set to retain a small part of the setup.
// - The bus carries 8-bit data, or the top eight of ten raw bits with the low two on aux pins.
// - The device drives a pixel clock on which the receiver samples data and both qualifiers.
// - The line qualifier is high only for pixels in the active part of a line.
// - The frame qualifier is high through the rows of the active image and low outside them.
// - Only one output path, serial or parallel, is active at a time, chosen by the host.
// - Two contexts are held and the host switches between them with a serial command.
// - The clock multiplier can be bypassed and is then powered down.
// - The host drives the slave serial clock and the data line runs both ways.
// - The device is master on a second two-wire port, driving its clock toward peripherals.
`timescale 1ns/1ps
module shp_pin_if (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Power and mode pins
    input wire logic standby_pin,
    input wire logic reset_pin_n,
    input wire logic shutdown_pin,
    input wire logic addr_select_pin,
    // Slave serial port
    input wire logic host_scl_pin,
    input wire logic host_sda_in,
    output logic host_sda_out,
    output logic host_sda_oe_n,
    // Master serial port
    output logic periph_scl_out,
    output logic periph_scl_oe_n,
    input wire logic periph_sda_in,
    output logic periph_sda_out,
    output logic periph_sda_oe_n,
    // Master write request
    input wire logic m_req,
    input wire logic [6:0] m_addr,
    input wire logic [7:0] m_data,
    output logic m_busy,
    output logic m_done,
    output logic m_nack,
    // Pixel stream from the pipeline
    input wire logic pix_valid,
    output logic pix_ready,
    input wire shp_pkg::shp_pix_word_type pix_word,
    // Parallel bus
    output logic pixel_strobe_clk,
    output logic [7:0] pix_dout,
    output logic line_valid,
    output logic frame_valid,
    output logic [7:0] aux_io_pins_out,
    output logic [7:0] aux_io_pins_oe_n,
    // Power and mode controls
    output logic core_rail_en,
    output logic supply_en,
    output logic pll_power_en,
    output logic pll_bypass,
    output logic serial_path_en,
    output logic active_ctx
);
    import shp_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic rst_s1, rst_s2, stb_s1, stb_s2, shd_s1, shd_s2, sel_s1, sel_s2;
        logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d, msda_s1, msda_s2;
        shp_sl_state_type sl_st;
        logic [3:0] sl_cnt;
        logic [7:0] sl_shift;
        logic sl_ack;
        shp_ctx_type [1:0] ctx;
        logic act;
        logic retain;
        logic [1:0] pix_div;
        logic pclk;
        logic [7:0] dout;
        logic [1:0] aux;
        logic lv, fv;
        shp_ms_state_type m_st;
        logic [6:0] m_tick;
        logic [1:0] m_ph;
        logic [4:0] m_bit;
        logic [17:0] m_frame;
        logic m_scl_low, m_sda_low, m_nack, m_done;
    } shp_state_type;

    shp_state_type st;
    shp_state_type next_st;
    shp_ctx_type cur;
    shp_pix_word_type buf_word;
    logic buf_valid;
    logic buf_pop;
    logic run;
    logic par_en;
    logic pix_tick;
    logic pix_fall;
    logic m_step;
    logic sl_start, sl_stop, sl_rise, sl_fall;

    // Device address picked by the address select level.
    function automatic logic [6:0] dev_addr(input logic sel);
        dev_addr = sel ? SL_ADDR_HIGH[7:1] : SL_ADDR_LOW[7:1];
    endfunction : dev_addr

    // ------------------------------------------------------------
    // Power, mode and edge terms
    // ------------------------------------------------------------
    // reset pin gate
    // The pad carries a pull-up, so a floating reset pin reads high and runs.
    assign run = st.rst_s2 && !st.stb_s2 && !st.shd_s2;
    assign cur = st.ctx[st.act];
    assign par_en = run && !cur.serial_path;
    assign serial_path_en = run && cur.serial_path;
    assign supply_en = !st.shd_s2;
    assign core_rail_en = !st.shd_s2 && !(st.stb_s2 && !st.retain);
    assign pll_bypass = cur.pll_bypass;
    assign pll_power_en = run && !cur.pll_bypass;
    assign active_ctx = st.act;
    assign pix_tick = st.pix_div == 2'(PIX_HALF_CYC - 1);
    assign pix_fall = pix_tick && st.pclk;
    assign buf_pop = par_en && pix_fall;
    assign m_step = st.m_tick == 7'(MS_TICK_CYC - 1);
    assign sl_rise = st.scl_s2 && !st.scl_d;
    assign sl_fall = !st.scl_s2 && st.scl_d;
    assign sl_start = st.scl_s2 && st.scl_d && st.sda_d && !st.sda_s2;
    assign sl_stop = st.scl_s2 && st.scl_d && !st.sda_d && st.sda_s2;

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // Open-drain pins only ever pull low, the enable carries the data.
    assign host_sda_out = 1'b0;
    assign host_sda_oe_n = !st.sl_ack;
    assign periph_scl_out = 1'b0;
    assign periph_scl_oe_n = !st.m_scl_low;
    assign periph_sda_out = 1'b0;
    assign periph_sda_oe_n = !st.m_sda_low;
    assign m_busy = st.m_st != MS_IDLE;
    assign m_done = st.m_done;
    assign m_nack = st.m_nack;
    assign pixel_strobe_clk = st.pclk;
    assign pix_dout = st.dout;
    assign line_valid = st.lv;
    assign frame_valid = st.fv;
    assign aux_io_pins_out = {6'h00, st.aux};
    assign aux_io_pins_oe_n = {6'h3f, ~{2{par_en && cur.raw10 && cur.aux_lsb}}};

    // Two words of slack so a stalled bus never drops a pipeline word.
    shp_pix_buf #(.WIDTH($bits(shp_pix_word_type)), .DEPTH(2)) u_buf (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(pix_valid),
        .in_ready(pix_ready),
        .in_data(pix_word),
        .out_valid(buf_valid),
        .out_ready(buf_pop),
        .out_data(buf_word)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Every pin from outside passes two flops before use.
        next_st.rst_s1 = reset_pin_n;
        next_st.rst_s2 = st.rst_s1;
        next_st.stb_s1 = standby_pin;
        next_st.stb_s2 = st.stb_s1;
        next_st.shd_s1 = shutdown_pin;
        next_st.shd_s2 = st.shd_s1;
        next_st.sel_s1 = addr_select_pin;
        next_st.sel_s2 = st.sel_s1;
        next_st.scl_s1 = host_scl_pin;
        next_st.scl_s2 = st.scl_s1;
        next_st.scl_d = st.scl_s2;
        next_st.sda_s1 = host_sda_in;
        next_st.sda_s2 = st.sda_s1;
        next_st.sda_d = st.sda_s2;
        next_st.msda_s1 = periph_sda_in;
        next_st.msda_s2 = st.msda_s1;
        next_st.m_done = 1'b0;

        // Slave serial port: write-only command receiver.
        if (sl_start) begin
            next_st.sl_st = SL_ADDR;
            next_st.sl_cnt = '0;
            next_st.sl_ack = 1'b0;
        end else if (sl_stop) begin
            next_st.sl_st = SL_IDLE;
            next_st.sl_ack = 1'b0;
        end else begin
            unique case (st.sl_st)
                SL_IDLE: begin
                end
                SL_ADDR, SL_DATA: begin
                    if (sl_rise && st.sl_cnt != SL_BITS) begin
                        next_st.sl_shift = {st.sl_shift[6:0], st.sda_s2};
                        next_st.sl_cnt = st.sl_cnt + 1'b1;
                    end else if (sl_fall && st.sl_cnt == SL_BITS) begin
                        if (st.sl_st == SL_DATA) begin
                            next_st.sl_ack = 1'b1;
                            next_st.sl_st = SL_DACK;
                            if (st.sl_shift[CMD_SWITCH_BIT]) begin
                                next_st.act = st.sl_shift[0];
                            end else begin
                                next_st.ctx[st.sl_shift[CMD_CTX_BIT]] = '{
                                    pll_bypass: st.sl_shift[CFG_BYPASS_BIT],
                                    serial_path: st.sl_shift[CFG_SERIAL_BIT],
                                    aux_lsb: st.sl_shift[CFG_AUX_BIT],
                                    raw10: st.sl_shift[CFG_RAW10_BIT]};
                                next_st.retain = st.sl_shift[CFG_RETAIN_BIT];
                            end
                        end else if (st.sl_shift[7:1] == dev_addr(st.sel_s2)
                                     && !st.sl_shift[0]) begin
                            next_st.sl_ack = 1'b1;
                            next_st.sl_st = SL_AACK;
                        end else begin
                            next_st.sl_st = SL_IDLE;
                        end
                    end
                end
                SL_AACK, SL_DACK: begin
                    if (sl_fall) begin
                        next_st.sl_ack = 1'b0;
                        next_st.sl_st = SL_DATA;
                        next_st.sl_cnt = '0;
                    end
                end
                // Three state bits leave unused codes; fall back to idle on any of them.
                default: begin
                    next_st.sl_st = SL_IDLE;
                end
            endcase
        end

        // pixel clock and falling-edge update
        // Updating on the falling edge leaves a half period of setup at the receiver.
        if (par_en) begin
            next_st.pix_div = pix_tick ? 2'h0 : st.pix_div + 1'b1;
            if (pix_tick) begin
                next_st.pclk = !st.pclk;
            end
            if (pix_fall) begin
                if (buf_valid) begin
                    next_st.dout = cur.raw10 ? buf_word.data[9:2] : buf_word.data[7:0];
                    next_st.aux = cur.raw10 ? buf_word.data[1:0] : 2'h0;
                    next_st.fv = buf_word.frame;
                    next_st.lv = buf_word.line && buf_word.frame;
                end else begin
                    next_st.lv = 1'b0;
                end
            end
        end else begin
            next_st.pix_div = '0;
            next_st.pclk = 1'b0;
            next_st.dout = '0;
            next_st.aux = '0;
            next_st.lv = 1'b0;
            next_st.fv = 1'b0;
        end

        // master serial write engine
        // No clock stretching: a peripheral that holds the clock low is not waited for.
        next_st.m_tick = (m_step || st.m_st == MS_IDLE) ? 7'h00 : st.m_tick + 1'b1;
        if (m_step) begin
            next_st.m_ph = st.m_ph + 1'b1;
        end
        unique case (st.m_st)
            MS_IDLE: begin
                next_st.m_ph = '0;
                if (m_req && run) begin
                    next_st.m_frame = {m_addr, 1'b0, 1'b1, m_data, 1'b1};
                    next_st.m_st = MS_START;
                    next_st.m_nack = 1'b0;
                end
            end
            MS_START: begin
                if (m_step && st.m_ph == 2'h0) begin
                    next_st.m_sda_low = 1'b1;
                end else if (m_step && st.m_ph == 2'h1) begin
                    next_st.m_scl_low = 1'b1;
                    next_st.m_st = MS_BITS;
                    next_st.m_ph = '0;
                    next_st.m_bit = '0;
                end
            end
            MS_BITS: begin
                if (m_step) begin
                    unique case (st.m_ph)
                        2'h0: next_st.m_sda_low = !st.m_frame[17];
                        2'h1: next_st.m_scl_low = 1'b0;
                        2'h2: begin
                            if ((st.m_bit == MS_ACK_POS0 || st.m_bit == MS_ACK_POS1)
                                && st.msda_s2) begin
                                next_st.m_nack = 1'b1;
                            end
                        end
                        2'h3: begin
                            next_st.m_scl_low = 1'b1;
                            next_st.m_frame = {st.m_frame[16:0], 1'b0};
                            next_st.m_bit = st.m_bit + 1'b1;
                            if (st.m_bit == MS_LAST_BIT) begin
                                next_st.m_st = MS_STOP;
                            end
                        end
                    endcase
                end
            end
            MS_STOP: begin
                if (m_step && st.m_ph == 2'h0) begin
                    next_st.m_sda_low = 1'b1;
                end else if (m_step && st.m_ph == 2'h1) begin
                    next_st.m_scl_low = 1'b0;
                end else if (m_step && st.m_ph == 2'h2) begin
                    next_st.m_sda_low = 1'b0;
                    next_st.m_st = MS_IDLE;
                    next_st.m_done = 1'b1;
                end
            end
        endcase

        if (!run) begin
            next_st.sl_st = SL_IDLE;
            next_st.sl_ack = 1'b0;
            next_st.m_st = MS_IDLE;
            next_st.m_scl_low = 1'b0;
            next_st.m_sda_low = 1'b0;
            if (!st.rst_s2 || st.shd_s2 || !st.retain) begin
                next_st.ctx = {CTX_RESET, CTX_RESET};
                next_st.act = 1'b0;
                next_st.retain = 1'b0;
            end
        end
    end

    // State register; serial-wire synchronisers reset high, the reset, standby, shutdown and select synchronisers low.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            // Serial wires idle high, so their flops do too and no false edge follows reset.
            st.scl_s1 <= 1'b1;
            st.scl_s2 <= 1'b1;
            st.scl_d <= 1'b1;
            st.sda_s1 <= 1'b1;
            st.sda_s2 <= 1'b1;
            st.sda_d <= 1'b1;
            st.msda_s1 <= 1'b1;
            st.msda_s2 <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_addr_ack: assert property ($rose(st.sl_ack) && $past(st.sl_st) == SL_ADDR
        |-> $past(st.sl_shift[7:1]) == dev_addr($past(st.sel_s2)))
        else $error("address acknowledged without a match");
    chk_standby_rail: assert property (st.stb_s2 && !st.retain |-> !core_rail_en)
        else $error("core rail on in standby without retain");
    chk_reset_quiet: assert property (!st.rst_s2 |=> !line_valid && !frame_valid)
        else $error("qualifiers active under master reset");
    chk_shutdown_supply: assert property (st.shd_s2 |-> !supply_en && !pll_power_en)
        else $error("supplies on during shutdown");
    chk_retain_keep: assert property (run && st.retain ##1 st.stb_s2
        |-> st.ctx == $past(st.ctx))
        else $error("retained setup lost on standby entry");
    chk_aux_lsb: assert property (aux_io_pins_oe_n[1:0] != 2'h3 |-> cur.raw10)
        else $error("aux pins driven outside raw10 mode");
    chk_line_frame: assert property (line_valid |-> frame_valid)
        else $error("line qualifier outside frame");
    chk_path_excl: assert property (serial_path_en
        |=> !pixel_strobe_clk && !line_valid && !frame_valid && pix_dout == 8'h00)
        else $error("parallel bus active on the serial path");
    chk_ctx_switch: assert property (sl_fall && st.sl_st == SL_DATA && st.sl_cnt == SL_BITS
        && st.sl_shift[CMD_SWITCH_BIT] && run |=> active_ctx == $past(st.sl_shift[0]))
        else $error("context switch not applied");
    chk_pll_bypass: assert property (pll_bypass |-> !pll_power_en)
        else $error("multiplier powered while bypassed");
    chk_master_idle: assert property (st.m_st == MS_IDLE ##1 st.m_st == MS_IDLE
        |-> periph_scl_oe_n && periph_sda_oe_n)
        else $error("master port driven while idle");
    chk_data_edge: assert property ($changed(pix_dout) && $past(par_en) && par_en
        |-> $fell(pixel_strobe_clk))
        else $error("pixel data changed off the falling edge");

endmodule : shp_pin_if

// >>> rtl/shp_pkg.sv
// Shared constants and types for the sensor host pin interface.
package shp_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    // Quarter bit time of the master serial port, a least time.
    localparam int MS_QUARTER_NS = 2500;
    localparam int MS_TICK_CYC = (MS_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Core cycles per half period of the pixel strobe clock.
    localparam int PIX_HALF_CYC = 2;

    // ------------------------------------------------------------
    // Slave serial port addresses (8-bit form, write direction)
    // ------------------------------------------------------------
    localparam logic [7:0] SL_ADDR_LOW = 8'h78;
    localparam logic [7:0] SL_ADDR_HIGH = 8'h7a;
    localparam logic [3:0] SL_BITS = 4'h8;

    // ------------------------------------------------------------
    // Command byte layout
    // ------------------------------------------------------------
    localparam int CMD_SWITCH_BIT = 7;
    localparam int CMD_CTX_BIT = 6;
    localparam int CFG_RETAIN_BIT = 4;
    localparam int CFG_BYPASS_BIT = 3;
    localparam int CFG_SERIAL_BIT = 2;
    localparam int CFG_AUX_BIT = 1;
    localparam int CFG_RAW10_BIT = 0;

    // ------------------------------------------------------------
    // Master serial frame
    // ------------------------------------------------------------
    localparam logic [4:0] MS_LAST_BIT = 5'h11;
    localparam logic [4:0] MS_ACK_POS0 = 5'h08;
    localparam logic [4:0] MS_ACK_POS1 = 5'h11;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic frame;
        logic line;
        logic [9:0] data;
    } shp_pix_word_type;

    typedef struct packed {
        logic pll_bypass;
        logic serial_path;
        logic aux_lsb;
        logic raw10;
    } shp_ctx_type;

    localparam shp_ctx_type CTX_RESET = 4'h0;

    typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_AACK, SL_DATA, SL_DACK} shp_sl_state_type;
    typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BITS, MS_STOP} shp_ms_state_type;

endpackage : shp_pkg

// >>> rtl/shp_pix_buf.sv
// Small pixel word buffer with valid and ready on both sides.
`timescale 1ns/1ps
module shp_pix_buf #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } shp_buf_state_type;

    shp_buf_state_type st;
    shp_buf_state_type next_st;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready = st.cnt != (AW + 1)'(DEPTH);
    assign out_valid = st.cnt != '0;
    assign out_data = st.mem[st.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointers wrap at the depth, so any depth works, not only powers of two.
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = in_data;
            next_st.wp = (st.wp == AW'(DEPTH - 1)) ? '0 : st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = (st.rp == AW'(DEPTH - 1)) ? '0 : st.rp + 1'b1;
        end
        if (push && !pop) begin
            next_st.cnt = st.cnt + 1'b1;
        end else if (pop && !push) begin
            next_st.cnt = st.cnt - 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : shp_pix_buf

// >>> test/shp_host_model.sv
// Host model: slave serial master and parallel bus receiver.
`timescale 1ns/1ps
module shp_host_model (
    // Serial control wires
    output logic scl,
    output logic sda_low,
    input wire logic sda,
    // Parallel bus
    input wire logic pclk,
    input wire logic fv,
    input wire logic lv,
    input wire logic [7:0] dout,
    input wire logic [7:0] aux,
    input wire logic [7:0] aux_oe_n
);
    logic [13:0] q[$];
    int n = 0;
    // The serial clock idles high and stands still between frames.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // sample on strobe
    // The receiver samples on the rising strobe, away from the launch edge.
    always @(posedge pclk) begin
        n++;
        q.push_back({fv, lv, dout, aux[1:0], aux_oe_n[1:0]});
    end
    // host drives clock
    // Data moves only while the clock is low, so no false start or stop.
    task automatic bit_out(input logic b, output logic s);
        sda_low = !b;
        #80 scl = 1'b1;
        #80 s = sda;
        #80 scl = 1'b0;
        #80;
    endtask : bit_out
    // Start, address, one command byte if acknowledged, then stop.
    task automatic frame(input logic [7:0] a, input logic [7:0] d, output logic ack);
        logic s;
        sda_low = 1'b1;
        #160 scl = 1'b0;
        #80;
        for (int i = 7; i >= 0; i--) bit_out(a[i], s);
        bit_out(1'b1, s);
        ack = !s;
        if (ack) begin
            for (int i = 7; i >= 0; i--) bit_out(d[i], s);
            bit_out(1'b1, s);
        end
        sda_low = 1'b1;
        #80 scl = 1'b1;
        #160 sda_low = 1'b0;
        #160;
    endtask : frame
endmodule : shp_host_model

// >>> test/tb_top.sv
// Self-checking bench for the sensor host pin interface.
`timescale 1ns/1ps
module tb_top;
    import shp_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic standby_pin = 1'b0, reset_pin_n = 1'b1, shutdown_pin = 1'b0, addr_select_pin = 1'b0;
    logic m_req = 1'b0, pix_valid = 1'b0, ack, host_scl_pin, host_low, host_sda_in;
    logic [6:0] m_addr = 7'h0c;
    logic [7:0] m_data = 8'h5a;
    shp_pix_word_type pix_word = '0;
    logic host_sda_out, host_sda_oe_n, periph_scl_out, periph_scl_oe_n, periph_sda_out;
    logic periph_sda_oe_n, m_busy, m_done, m_nack, pix_ready, pixel_strobe_clk, line_valid;
    logic frame_valid, core_rail_en, supply_en, pll_power_en, pll_bypass, serial_path_en;
    logic active_ctx, periph_sda_in;
    logic [7:0] pix_dout, aux_io_pins_out, aux_io_pins_oe_n;
    logic [13:0] ex[3];
    int err_count = 0, compares = 0, cyc = 0, rel = 0, k;
    // Open-drain wires with pull-ups; no peripheral answers on the master port.
    assign host_sda_in = !(host_low || !host_sda_oe_n);
    assign periph_sda_in = periph_sda_oe_n;
    always #20 clock = ~clock;
    always @(posedge periph_scl_oe_n) rel++;
    shp_pin_if dut (.clock, .rst_n, .standby_pin, .reset_pin_n, .shutdown_pin,
        .addr_select_pin, .host_scl_pin, .host_sda_in, .host_sda_out, .host_sda_oe_n,
        .periph_scl_out, .periph_scl_oe_n, .periph_sda_in, .periph_sda_out, .periph_sda_oe_n,
        .m_req, .m_addr, .m_data, .m_busy, .m_done, .m_nack, .pix_valid, .pix_ready, .pix_word,
        .pixel_strobe_clk, .pix_dout, .line_valid, .frame_valid, .aux_io_pins_out,
        .aux_io_pins_oe_n, .core_rail_en, .supply_en, .pll_power_en, .pll_bypass,
        .serial_path_en, .active_ctx);
    shp_host_model host (.scl(host_scl_pin), .sda_low(host_low), .sda(host_sda_in),
        .pclk(pixel_strobe_clk), .fv(frame_valid), .lv(line_valid), .dout(pix_dout),
        .aux(aux_io_pins_out), .aux_oe_n(aux_io_pins_oe_n));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cw(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask : cw
    task automatic conclude;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    // A hang counts as a mismatch and ends the run.
    always @(posedge clock) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            conclude();
        end
    end
    task automatic t_master;
        rel = 0;
        m_req = 1'b1;
        for (int i = 0; i < 20 && m_busy !== 1'b1; i++) cw(1);
        m_req = 1'b0;
        for (int i = 0; i < 6000 && m_done !== 1'b1; i++) cw(1);
        chk({m_done, m_nack}, 2'b11);
        chk(rel, 19);
        $display("master done");
    endtask : t_master
    task automatic t_addr;
        host.frame(8'h7a, 8'h81, ack);
        chk(ack, 0);
        host.frame(8'h78, 8'h81, ack);
        chk({ack, active_ctx}, 2'b11);
        cw(1);
        addr_select_pin = 1'b1;
        host.frame(8'h78, 8'h80, ack);
        chk(ack, 0);
        host.frame(8'h7a, 8'h80, ack);
        chk({ack, active_ctx}, 2'b10);
        $display("addr done");
    endtask : t_addr
    task automatic push(input shp_pix_word_type w);
        pix_word = w;
        pix_valid = 1'b1;
        for (int i = 0; i < 50 && pix_ready !== 1'b1; i++) cw(1);
        cw(1);
    endtask : push
    task automatic t_pix;
        host.frame(8'h7a, 8'h0b, ack);
        chk({pll_bypass, pll_power_en}, 2'b10);
        ex[0] = {2'b11, 8'ha9, 4'h4};
        ex[1] = {2'b10, 8'h56, 4'h8};
        ex[2] = {2'b00, 8'hff, 4'hc};
        cw(1);
        host.q.delete();
        push({1'b1, 1'b1, 10'h2a5});
        push({1'b1, 1'b0, 10'h15a});
        push({1'b0, 1'b1, 10'h3ff});
        pix_valid = 1'b0;
        cw(40);
        k = 0;
        foreach (host.q[i]) if (k < 3 && host.q[i] === ex[k]) k++;
        chk(k, 3);
        $display("pixel done");
    endtask : t_pix
    task automatic t_path;
        host.frame(8'h7a, 8'h14, ack);
        k = host.n;
        cw(20);
        chk({serial_path_en, host.n == k}, 2'b11);
        push('0);
        push('0);
        pix_valid = 1'b0;
        chk(pix_ready, 0);
        standby_pin = 1'b1;
        cw(6);
        standby_pin = 1'b0;
        cw(6);
        chk(serial_path_en, 1);
        host.frame(8'h7a, 8'h04, ack);
        cw(1);
        standby_pin = 1'b1;
        cw(6);
        chk(core_rail_en, 0);
        standby_pin = 1'b0;
        cw(6);
        chk({core_rail_en, serial_path_en}, 2'b10);
        $display("path done");
    endtask : t_path
    task automatic t_power;
        shutdown_pin = 1'b1;
        cw(6);
        chk(supply_en, 0);
        shutdown_pin = 1'b0;
        cw(6);
        host.frame(8'h7a, 8'h81, ack);
        cw(1);
        reset_pin_n = 1'b0;
        cw(6);
        chk({supply_en, active_ctx}, 2'b10);
        reset_pin_n = 1'b1;
        $display("power done");
    endtask : t_power
    initial begin
        cw(5);
        rst_n = 1'b1;
        cw(3);
        chk({pixel_strobe_clk, host_sda_oe_n, periph_scl_oe_n, m_busy, pix_ready}, 5'h0d);
        t_master();
        t_addr();
        t_pix();
        t_path();
        t_power();
        conclude();
    end
endmodule : tb_top
